// ---- logic/flash_prot_pkg.sv ----
package flash_prot_pkg;
   localparam int          ADR_W           = 8;
   localparam int          DAT_W           = 32;
   localparam logic [7:0]  CTL_ONE_OFF     = 8'h00;
   localparam logic [7:0]  CTL_TWO_OFF     = 8'h04;
   localparam logic [7:0]  BLK_ONE_OFF     = 8'h08;
   localparam logic [7:0]  BLK_TWO_OFF     = 8'h0c;
   localparam logic [7:0]  OVL_OFF         = 8'h10;
   localparam logic [7:0]  STATE_OFF       = 8'h14;
   localparam logic [7:0]  IRQ_STAT_OFF    = 8'h18;
   localparam logic [7:0]  IRQ_MASK_OFF    = 8'h1c;
   localparam int          PROG_BIT        = 0;
   localparam int          ERASE_BIT       = 1;
   localparam int          PVER_BIT        = 2;
   localparam int          EVER_BIT        = 3;
   localparam int          SWE_BIT         = 6;
   localparam int          FERR_BIT        = 7;
   localparam int          OVL_SEL_BIT     = 3;
   localparam int          OVL_AREA_W      = 2;
   localparam int          IRQ_W           = 3;
   localparam int          EV_ERROR        = 0;
   localparam int          EV_REFUSED      = 1;
   localparam int          EV_ABORT        = 2;
   localparam logic [7:0]  CTL_RST         = 8'h00;
   localparam logic [7:0]  BLK_RST         = 8'h00;
   localparam logic [7:0]  OVL_RST         = 8'h00;
   localparam logic [2:0]  IRQ_RST         = 3'h0;
   localparam logic [7:0]  CTL_ONE_WMASK   = 8'h4f;
   localparam logic [7:0]  CTL_TWO_WMASK   = 8'h0f;
   localparam logic [7:0]  OVL_WMASK       = 8'h0b;
   typedef enum logic [1:0] {
      M_IDLE,
      M_PROG,
      M_ERASE,
      M_VERIFY
   } mode_t;
endpackage

// ---- logic/fault_detect.sv ----
`timescale 1ns/1ps
module fault_detect
   import flash_prot_pkg::*;
(
   input  wire logic busy_i,
   input  wire logic flash_read_i,
   input  wire logic exception_i,
   input  wire logic sleep_i,
   input  wire logic bus_release_i,
   output logic      fault_o
);
   // Illegal activity during program or erase
   always_comb begin
      fault_o = busy_i & (flash_read_i
                        | exception_i
                        | sleep_i
                        | bus_release_i);
   end
endmodule

// ---- logic/irq_status.sv ----
`timescale 1ns/1ps
module irq_status
   import flash_prot_pkg::*;
(
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic [IRQ_W-1:0] event_i,
   input  wire logic             clr_we_i,
   input  wire logic [IRQ_W-1:0] clr_i,
   input  wire logic             mask_we_i,
   input  wire logic [IRQ_W-1:0] mask_i,
   output logic      [IRQ_W-1:0] status_o,
   output logic      [IRQ_W-1:0] mask_o,
   output logic                  irq_o
);
   typedef struct packed {
      logic [IRQ_W-1:0] stat;
      logic [IRQ_W-1:0] mask;
      logic             irq;
   } irq_state_t;
   irq_state_t s_q;
   irq_state_t s_d;
   // Set wins over a write-one clear
   always_comb begin
      s_d      = s_q;
      if (clr_we_i) begin
         s_d.stat = s_q.stat & ~clr_i;
      end
      s_d.stat = s_d.stat | event_i;
      if (mask_we_i) begin
         s_d.mask = mask_i;
      end
      s_d.irq  = |(s_d.stat & s_d.mask);
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '{stat: IRQ_RST, mask: IRQ_RST, irq: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end
   assign status_o = s_q.stat;
   assign mask_o   = s_q.mask;
   assign irq_o    = s_q.irq;
endmodule

// ---- logic/flash_protect.sv ----
`timescale 1ns/1ps
// Functional notes
// - Guard pin high resets registers, protects all
// - Reset, watchdog, standby reset registers, protect
// - Software protection ignores program/erase sets
// - Write-enable zero protects every block
// - Erase only selected blocks; none selected
// - Overlay select one protects all blocks
// - Error sets flag, aborts program/erase
// - Error keeps registers, refuses program/erase
// - Error still allows verify mode entry
// - Flash read while busy raises error
// - Non-reset exception while busy raises error
// - Sleep while busy raises error
// - Bus release while busy raises error
// - Only reset, watchdog overflow or hardware standby clears error
module flash_protect
   import flash_prot_pkg::*;
(
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [DAT_W-1:0] wb_dat_i,
   output logic      [DAT_W-1:0] wb_dat_o,
   output logic                  wb_ack_o,
   input  wire logic             flash_write_guard_pin_i,
   input  wire logic             watchdog_overflow_i,
   input  wire logic             hw_standby_i,
   input  wire logic             flash_read_i,
   input  wire logic             exception_i,
   input  wire logic             sleep_i,
   input  wire logic             bus_release_i,
   output logic                  program_mode_o,
   output logic                  erase_mode_o,
   output logic                  verify_mode_o,
   output logic      [15:0]      erase_blocks_o,
   output logic                  flash_error_flag_o,
   output logic                  irq_o
);
   import flash_prot_pkg::*;

   typedef struct packed {
      logic [7:0]       ctl_one;
      logic [7:0]       ctl_two;
      logic [7:0]       blk_one;
      logic [7:0]       blk_two;
      logic [7:0]       ovl;
      logic             ferr;
      mode_t            mode;
      logic [15:0]      blocks;
      logic             prog_out;
      logic             erase_out;
      logic             verify_out;
      logic             ack;
      logic [DAT_W-1:0] rdat;
   } prot_state_t;

   prot_state_t      s_q;
   prot_state_t      s_d;
   logic             fault;
   logic             busy;
   logic             init;
   logic             prog_ok;
   logic             erase_ok;
   logic             req;
   logic             wr;
   logic             refused;
   logic             abort;
   logic [IRQ_W-1:0] irq_stat;
   logic [IRQ_W-1:0] irq_mask;
   logic [7:0]       wbyte;

   function automatic logic hit(input logic [ADR_W-1:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
                                        input logic [7:0] wm);
      return (old & ~wm) | (nw & wm);
   endfunction

   assign busy  = (s_q.mode == M_PROG) || (s_q.mode == M_ERASE);
   assign init  = flash_write_guard_pin_i | watchdog_overflow_i | hw_standby_i;
   assign req   = wb_cyc_i & wb_stb_i & ~s_q.ack;
   assign wr    = req & wb_we_i & wb_sel_i[0];
   assign wbyte = wb_dat_i[7:0];

   fault_detect u_fault (
      .busy_i        (busy),
      .flash_read_i  (flash_read_i),
      .exception_i   (exception_i),
      .sleep_i       (sleep_i),
      .bus_release_i (bus_release_i),
      .fault_o       (fault)
   );

   // Combined program and erase qualification
   always_comb begin
      prog_ok  = s_q.ctl_one[SWE_BIT]
               & ~s_q.ovl[OVL_SEL_BIT]
               & ~s_q.ferr
               & ~fault
               & ~flash_write_guard_pin_i;
      erase_ok = prog_ok
               & ((s_q.blk_one | s_q.blk_two) != 8'h00);
   end

   // Register writes and mode state
   always_comb begin
      s_d     = s_q;
      refused = 1'b0;
      abort   = 1'b0;
      s_d.ack = req;
      if (req && !wb_we_i) begin
         unique case (1'b1)
            hit(wb_adr_i, CTL_ONE_OFF):  s_d.rdat = {24'h0, s_q.ctl_one};
            hit(wb_adr_i, CTL_TWO_OFF):  s_d.rdat = {24'h0, s_q.ctl_two[7:0]
                                                     | {s_q.ferr, 7'h00}};
            hit(wb_adr_i, BLK_ONE_OFF):  s_d.rdat = {24'h0, s_q.blk_one};
            hit(wb_adr_i, BLK_TWO_OFF):  s_d.rdat = {24'h0, s_q.blk_two};
            hit(wb_adr_i, OVL_OFF):      s_d.rdat = {24'h0, s_q.ovl};
            hit(wb_adr_i, STATE_OFF):    s_d.rdat = {27'h0, s_q.ferr,
                                                     erase_ok, prog_ok, s_q.mode};
            hit(wb_adr_i, IRQ_STAT_OFF): s_d.rdat = {29'h0, irq_stat};
            hit(wb_adr_i, IRQ_MASK_OFF): s_d.rdat = {29'h0, irq_mask};
            default:                     s_d.rdat = '0;
         endcase
      end
      if (wr && hit(wb_adr_i, CTL_ONE_OFF)) begin
         s_d.ctl_one = merge(s_q.ctl_one, wbyte, CTL_ONE_WMASK);
         if (!prog_ok && wbyte[PROG_BIT] && !s_q.ctl_one[PROG_BIT]) begin
            s_d.ctl_one[PROG_BIT] = 1'b0;
            refused               = 1'b1;
         end
         if (!erase_ok && wbyte[ERASE_BIT] && !s_q.ctl_one[ERASE_BIT]) begin
            s_d.ctl_one[ERASE_BIT] = 1'b0;
            refused                = 1'b1;
         end
      end
      if (wr && hit(wb_adr_i, CTL_TWO_OFF)) begin
         s_d.ctl_two = merge(s_q.ctl_two, wbyte, CTL_TWO_WMASK);
         if (!prog_ok && wbyte[PROG_BIT] && !s_q.ctl_two[PROG_BIT]) begin
            s_d.ctl_two[PROG_BIT] = 1'b0;
            refused               = 1'b1;
         end
         if (!erase_ok && wbyte[ERASE_BIT] && !s_q.ctl_two[ERASE_BIT]) begin
            s_d.ctl_two[ERASE_BIT] = 1'b0;
            refused                = 1'b1;
         end
      end
      if (wr && hit(wb_adr_i, BLK_ONE_OFF)) begin
         s_d.blk_one = wbyte;
      end
      if (wr && hit(wb_adr_i, BLK_TWO_OFF)) begin
         s_d.blk_two = wbyte;
      end
      if (wr && hit(wb_adr_i, OVL_OFF)) begin
         s_d.ovl = merge(s_q.ovl, wbyte, OVL_WMASK);
      end
      // Mode follows the control bits; program and erase entry gated by the qualification, verify not
      unique case (s_q.mode)
         M_IDLE, M_VERIFY: begin
            if (prog_ok && (s_d.ctl_one[PROG_BIT] || s_d.ctl_two[PROG_BIT])) begin
               s_d.mode = M_PROG;
            end else if (erase_ok
                         && (s_d.ctl_one[ERASE_BIT] || s_d.ctl_two[ERASE_BIT])) begin
               s_d.mode = M_ERASE;
            end else if (s_d.ctl_one[PVER_BIT] || s_d.ctl_one[EVER_BIT]
                         || s_d.ctl_two[PVER_BIT] || s_d.ctl_two[EVER_BIT]) begin
               s_d.mode = M_VERIFY;
            end else begin
               s_d.mode = M_IDLE;
            end
         end
         M_PROG: begin
            if (!prog_ok) begin
               s_d.mode = M_IDLE;
               abort    = 1'b1;
            end else if (!s_d.ctl_one[PROG_BIT] && !s_d.ctl_two[PROG_BIT]) begin
               s_d.mode = M_IDLE;
            end
         end
         M_ERASE: begin
            if (!erase_ok) begin
               s_d.mode = M_IDLE;
               abort    = 1'b1;
            end else if (!s_d.ctl_one[ERASE_BIT] && !s_d.ctl_two[ERASE_BIT]) begin
               s_d.mode = M_IDLE;
            end
         end
      endcase
      if (fault) begin
         s_d.ferr = 1'b1;
         s_d.mode = M_IDLE;
      end
      s_d.blocks = (s_d.mode == M_ERASE) ? {s_d.blk_two, s_d.blk_one} : 16'h0000;
      if (init) begin
         s_d.ctl_one = CTL_RST;
         s_d.ctl_two = CTL_RST;
         s_d.blk_one = BLK_RST;
         s_d.blk_two = BLK_RST;
         s_d.mode    = M_IDLE;
         s_d.blocks  = 16'h0000;
      end
      if (watchdog_overflow_i || hw_standby_i) begin
         s_d.ferr = 1'b0;
      end
      s_d.prog_out   = s_d.mode == M_PROG;
      s_d.erase_out  = s_d.mode == M_ERASE;
      s_d.verify_out = s_d.mode == M_VERIFY;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '{ctl_one: CTL_RST, ctl_two: CTL_RST, blk_one: BLK_RST,
                  blk_two: BLK_RST, ovl: OVL_RST, ferr: 1'b0, mode: M_IDLE,
                  blocks: 16'h0000, prog_out: 1'b0, erase_out: 1'b0,
                  verify_out: 1'b0, ack: 1'b0, rdat: '0};
      end else begin
         s_q <= s_d;
      end
   end

   irq_status u_irq (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .event_i   ({abort | fault, refused, fault & ~s_q.ferr}),
      .clr_we_i  (wr && hit(wb_adr_i, IRQ_STAT_OFF)),
      .clr_i     (wbyte[IRQ_W-1:0]),
      .mask_we_i (wr && hit(wb_adr_i, IRQ_MASK_OFF)),
      .mask_i    (wbyte[IRQ_W-1:0]),
      .status_o  (irq_stat),
      .mask_o    (irq_mask),
      .irq_o     (irq_o)
   );

   assign wb_dat_o           = s_q.rdat;
   assign wb_ack_o           = s_q.ack;
   assign program_mode_o     = s_q.prog_out;
   assign erase_mode_o       = s_q.erase_out;
   assign verify_mode_o      = s_q.verify_out;
   assign erase_blocks_o     = s_q.blocks;
   assign flash_error_flag_o = s_q.ferr;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_guard_init_regs: assert property (
      flash_write_guard_pin_i |=> s_q.ctl_one == CTL_RST && s_q.blk_one == BLK_RST
                                  && !program_mode_o && !erase_mode_o)
      else $error("guard pin did not clear registers");

   a_guard_regs_two: assert property (
      flash_write_guard_pin_i |=> s_q.ctl_two == CTL_RST && s_q.blk_two == BLK_RST)
      else $error("guard pin left upper registers set");

   a_watchdog_init: assert property (
      watchdog_overflow_i |=> s_q.ctl_two == CTL_RST && s_q.blk_two == BLK_RST
                              && !flash_error_flag_o)
      else $error("watchdog reset did not initialize");

   a_standby_init: assert property (
      hw_standby_i |=> s_q.ctl_one == CTL_RST && s_q.blk_one == BLK_RST
                       && !flash_error_flag_o && !program_mode_o && !erase_mode_o)
      else $error("standby did not initialize");

   a_swe_blocks_prog: assert property (
      !s_q.ctl_one[SWE_BIT] |=> !program_mode_o && !erase_mode_o)
      else $error("mode entered without write enable");

   a_no_block_erase: assert property (
      (s_q.blk_one | s_q.blk_two) == 8'h00 |=> !erase_mode_o)
      else $error("erase with no block selected");

   a_overlay_protect: assert property (
      s_q.ovl[OVL_SEL_BIT] |=> !program_mode_o && !erase_mode_o)
      else $error("mode entered while overlay selected");

   a_fault_aborts: assert property (
      fault && !init && !watchdog_overflow_i && !hw_standby_i
      |=> flash_error_flag_o && !program_mode_o && !erase_mode_o)
      else $error("fault did not set flag and abort");

   a_fault_irq: assert property (
      fault && !s_q.ferr |=> irq_stat[EV_ERROR] && irq_stat[EV_ABORT])
      else $error("fault not recorded in status");

   a_abort_irq: assert property (
      abort |=> irq_stat[EV_ABORT])
      else $error("abort not recorded in status");

   a_error_refuses: assert property (
      flash_error_flag_o && !$rose(flash_error_flag_o) |-> !program_mode_o && !erase_mode_o)
      else $error("program or erase while in error");

   a_error_keeps: assert property (
      flash_error_flag_o && !init && !wr |=> $stable(s_q.ctl_one) && $stable(s_q.ctl_two)
                                             && $stable(s_q.blk_one) && $stable(s_q.blk_two))
      else $error("registers changed in error state");

   a_error_sticky: assert property (
      flash_error_flag_o && !watchdog_overflow_i && !hw_standby_i |=> flash_error_flag_o)
      else $error("error flag cleared without reset");

   a_sw_refused: assert property (
      wr && hit(wb_adr_i, CTL_ONE_OFF) && wbyte[PROG_BIT] && !s_q.ctl_one[PROG_BIT]
      && !prog_ok && !init |=> !s_q.ctl_one[PROG_BIT])
      else $error("program bit stored under protection");

   a_erase_refused: assert property (
      wr && hit(wb_adr_i, CTL_ONE_OFF) && wbyte[ERASE_BIT] && !s_q.ctl_one[ERASE_BIT]
      && !erase_ok |=> !s_q.ctl_one[ERASE_BIT])
      else $error("erase bit stored under protection");

   a_upper_refused: assert property (
      wr && hit(wb_adr_i, CTL_TWO_OFF) && wbyte[PROG_BIT] && !s_q.ctl_two[PROG_BIT]
      && !prog_ok |=> !s_q.ctl_two[PROG_BIT])
      else $error("upper program bit stored under protection");

   a_refused_irq: assert property (
      refused |=> irq_stat[EV_REFUSED])
      else $error("refused write not recorded");

   a_verify_in_error: assert property (
      flash_error_flag_o && !busy && !init && wr
      && (hit(wb_adr_i, CTL_ONE_OFF) || hit(wb_adr_i, CTL_TWO_OFF))
      && wbyte[PVER_BIT] |=> verify_mode_o)
      else $error("verify refused in error state");

   a_prog_qualified: assert property (
      $rose(program_mode_o) |-> $past(prog_ok))
      else $error("program mode entered unqualified");

   a_erase_qualified: assert property (
      $rose(erase_mode_o) |-> $past(erase_ok))
      else $error("erase mode entered unqualified");

   a_ack_one_cycle: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   a_erase_blocks: assert property (
      erase_mode_o |-> erase_blocks_o == {s_q.blk_two, s_q.blk_one})
      else $error("erase block output mismatch");

   a_blocks_idle: assert property (
      !erase_mode_o |-> erase_blocks_o == 16'h0000)
      else $error("erase blocks shown outside erase");
endmodule

// ---- verif/flash_protect_tb.sv ----
`timescale 1ns/1ps
module flash_protect_tb;
   import flash_prot_pkg::*;
   logic              clk_i;
   logic              rst_i;
   logic              wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [ADR_W-1:0]  wb_adr_i;
   logic [3:0]        wb_sel_i;
   logic [DAT_W-1:0]  wb_dat_i, wb_dat_o;
   logic              guard_q;
   logic [5:0]        ev_q;
   logic              program_mode_o, erase_mode_o, verify_mode_o, flash_error_flag_o, irq_o;
   logic [15:0]       erase_blocks_o;
   logic [31:0]       exp_q[$];
   logic [7:0]        v, w;
   int                fails, n_checks, k, seed_v;
   localparam logic [7:0] OFFS [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c,
                                       8'h20};

   flash_protect dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .flash_write_guard_pin_i(guard_q),
      .watchdog_overflow_i(ev_q[4]), .hw_standby_i(ev_q[5]), .flash_read_i(ev_q[0]),
      .exception_i(ev_q[1]), .sleep_i(ev_q[2]), .bus_release_i(ev_q[3]),
      .program_mode_o(program_mode_o), .erase_mode_o(erase_mode_o),
      .verify_mode_o(verify_mode_o), .erase_blocks_o(erase_blocks_o),
      .flash_error_flag_o(flash_error_flag_o), .irq_o(irq_o));

   always #2.5 clk_i = ~clk_i;

   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk_vec(input logic [31:0] got, input logic [31:0] exp, input string msg);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp, input string msg);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %0t %s got %b exp %b", $time, msg, got, exp);
      end
   endtask

   // Classic single cycle, released at the edge where ack is seen
   task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      int t;
      t = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= s;
      do begin
         @(posedge clk_i);
         t++;
      end while (wb_ack_o !== 1'b1 && t < 50);
      if (t >= 50) begin
         fails++;
         $display("MISMATCH %0t no ack", $time);
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hf);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 32'h0, 4'hf);
   endtask

   // One-cycle pulse on a side input, outputs checked after it lands
   task automatic pulse(input int n);
      @(posedge clk_i);
      ev_q[n] <= 1'b1;
      @(posedge clk_i);
      ev_q <= '0;
      @(negedge clk_i);
   endtask

   task automatic reset_dut;
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask

   // Read results checked in order as acks appear
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && !wb_we_i) begin
         if (exp_q.size() > 0) begin
            chk_vec(wb_dat_o, exp_q.pop_front(), "read data");
         end else begin
            fails++;
            $display("MISMATCH %0t unexpected ack", $time);
         end
      end
   end

   initial begin
      #(5 * 20000);
      fails++;
      $display("MISMATCH %0t watchdog expired", $time);
      final_report();
   end

   initial begin
      clk_i = 1'b0; rst_i = 1'b1; guard_q = 1'b0; ev_q = '0; fails = 0; n_checks = 0;
      wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0; wb_adr_i = '0; wb_sel_i = '0;
      wb_dat_i = '0;
      seed_v = $urandom(32'he9ff);
      reset_dut();
      foreach (OFFS[j]) rd(OFFS[j], 32'h0);
      wr(CTL_ONE_OFF, 32'h03);
      rd(CTL_ONE_OFF, 32'h0);
      rd(STATE_OFF, 32'h0);
      bus(1'b1, CTL_ONE_OFF, 32'h40, 4'he);
      rd(CTL_ONE_OFF, 32'h0);
      wr(CTL_ONE_OFF, 32'h40);
      wr(CTL_ONE_OFF, 32'h41);
      chk_bit(program_mode_o, 1'b1, "program entry");
      rd(STATE_OFF, 32'h05);
      wr(CTL_ONE_OFF, 32'h00);
      chk_bit(program_mode_o | flash_error_flag_o, 1'b0, "write enable cleared");
      wr(CTL_ONE_OFF, 32'h40);
      wr(CTL_ONE_OFF, 32'h42);
      chk_bit(erase_mode_o, 1'b0, "erase with no block");
      v = 8'($urandom()) | 8'h01;
      w = 8'($urandom());
      wr(BLK_ONE_OFF, {24'h0, v});
      wr(BLK_TWO_OFF, {24'h0, w});
      wr(CTL_ONE_OFF, 32'h42);
      chk_bit(erase_mode_o, 1'b1, "erase entry");
      chk_vec({16'h0, erase_blocks_o}, {16'h0, w, v}, "erase blocks");
      rd(STATE_OFF, 32'h0e);
      wr(CTL_ONE_OFF, 32'h40);
      wr(CTL_TWO_OFF, 32'h02);
      chk_bit(erase_mode_o, 1'b1, "upper erase entry");
      wr(CTL_TWO_OFF, 32'h00);
      wr(OVL_OFF, 32'h08);
      wr(CTL_ONE_OFF, 32'h41);
      chk_bit(program_mode_o, 1'b0, "overlay blocks program");
      wr(CTL_TWO_OFF, 32'h01);
      rd(CTL_TWO_OFF, 32'h0);
      rd(STATE_OFF, 32'h0);
      wr(OVL_OFF, 32'h00);
      wr(CTL_ONE_OFF, 32'h41);
      @(posedge clk_i);
      guard_q <= 1'b1;
      @(posedge clk_i);
      @(negedge clk_i);
      chk_bit(program_mode_o, 1'b0, "guard abort");
      rd(CTL_ONE_OFF, 32'h0);
      wr(CTL_ONE_OFF, 32'h41);
      chk_bit(program_mode_o, 1'b0, "guard refuses");
      guard_q <= 1'b0;
      for (k = 0; k < 4; k++) begin
         reset_dut();
         wr(CTL_ONE_OFF, 32'h40);
         wr(CTL_ONE_OFF, 32'h41);
         pulse(k);
         chk_bit(flash_error_flag_o, 1'b1, "fault sets flag");
         chk_bit(program_mode_o, 1'b0, "fault aborts");
         rd(CTL_ONE_OFF, 32'h41);
         rd(IRQ_STAT_OFF, 32'h05);
         rd(CTL_TWO_OFF, 32'h80);
         wr(CTL_ONE_OFF, 32'h41);
         chk_bit(program_mode_o, 1'b0, "no reentry");
         wr(CTL_ONE_OFF, 32'h44);
         chk_bit(verify_mode_o, 1'b1, "verify in error");
         rd(STATE_OFF, 32'h13);
         wr(CTL_TWO_OFF, 32'h00);
         chk_bit(flash_error_flag_o, 1'b1, "write keeps flag");
         if (k < 2) begin
            pulse(k + 4);
         end else begin
            reset_dut();
            @(negedge clk_i);
         end
         chk_bit(flash_error_flag_o, 1'b0, "flag cleared");
      end
      reset_dut();
      wr(CTL_ONE_OFF, 32'h01);
      rd(IRQ_STAT_OFF, 32'h02);
      chk_bit(irq_o, 1'b0, "masked irq");
      wr(IRQ_MASK_OFF, 32'h02);
      chk_bit(irq_o, 1'b1, "unmasked irq");
      wr(IRQ_STAT_OFF, 32'h02);
      chk_bit(irq_o, 1'b0, "cleared irq");
      rd(IRQ_STAT_OFF, 32'h0);
      repeat (3) @(posedge clk_i);
      final_report();
   end
endmodule
